//--- common/wdt_pkg.sv
// shared constants, types and address decode for the chip watchdog
package wdt_pkg;

	// ****************************************************************
	// register map: printed offsets are word indices, byte address = 4*index
	// ****************************************************************
	localparam int              IDX_W      = 16;
	localparam int              ADDR_LSB   = 2;
	localparam logic [IDX_W-1:0] IDX_NONE  = 16'h0000;
	localparam logic [IDX_W-1:0] IDX_CTRL  = 16'hF020;
	localparam logic [IDX_W-1:0] IDX_LIVE  = 16'hF021;
	localparam logic [IDX_W-1:0] IDX_LIMIT = 16'hF022;
	localparam logic [IDX_W-1:0] IDX_COUNT = 16'hF023;
	localparam logic [IDX_W-1:0] IDX_HIST  = 16'hF024;

	// ****************************************************************
	// fields and reset values
	// ****************************************************************
	localparam int          CTRL_COUNT_EN_BIT = 0;
	localparam int          CTRL_TRIG_EN_BIT  = 1;
	localparam int          HIST_TRIG_BIT     = 0;
	localparam int          PRESC_W_DEF       = 16;
	localparam int          COUNT_W_DEF       = 12;
	localparam logic [15:0] LIMIT_RST         = 16'hFFFF;
	localparam logic [15:0] PRESC_RST         = 16'h0000;
	localparam logic [11:0] COUNT_RST         = 12'hFFF;
	localparam logic [11:0] COUNT_ZERO        = 12'h000;
	localparam int          CHIP_RST_CYCLES   = 4;

	// ****************************************************************
	// bus encodings
	// ****************************************************************
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic       HRESP_OKAY = 1'h0;

	typedef logic [31:0] word_t;

	typedef enum logic [1:0]
	{
		ST_RUN    = 2'h0,
		ST_FIRE   = 2'h1,
		ST_SETTLE = 2'h3
	} fire_state_t;

	// word index of an aligned in-range address, IDX_NONE otherwise
	function automatic logic [IDX_W-1:0] map_index(input word_t addr);
		logic ok;
		ok = (addr[ADDR_LSB-1:0] == '0) && (addr[31:IDX_W+ADDR_LSB] == '0);
		return ok ? addr[IDX_W+ADDR_LSB-1:ADDR_LSB] : IDX_NONE;
	endfunction : map_index

endpackage : wdt_pkg

//--- common/wdt_reg_if.sv
// register access carrier between the bus slave and the watchdog core
`timescale 1ns/1ps
interface wdt_reg_if;
	logic                        wr_en;
	logic [wdt_pkg::IDX_W-1:0]   wr_idx;
	wdt_pkg::word_t              wr_data;
	logic [wdt_pkg::IDX_W-1:0]   rd_idx;
	wdt_pkg::word_t              rd_data;

	modport bus
	(
		output wr_en,
		output wr_idx,
		output wr_data,
		output rd_idx,
		input  rd_data
	);

	modport regs
	(
		input  wr_en,
		input  wr_idx,
		input  wr_data,
		input  rd_idx,
		output rd_data
	);
endinterface : wdt_reg_if

//--- rtl/prescaled_chip_watchdog.sv
// chip watchdog: prescaler, timeout countdown, chip reset and trigger history
//
// Behaviour
// RULE1: watchdog idle after reset, no chip reset
// RULE2: control bit 0 gates the countdown decrement
// RULE3: control bit 1 lets expiry reset chip
// RULE4: count without trigger is a legal mode
// RULE5: prescaler counts oscillator edges, wraps, decrements count
// RULE6: live prescaler value readable as free timer
// RULE7: divider limit writable, resets all ones, divides by limit+1
// RULE8: 12-bit timeout count, resets all ones, decrements
// RULE9: zero count with trigger enabled resets chip; the code also needs control bit 0 set
// RULE10: software rewrites count before it reaches zero
// RULE11: status bit 0 set once triggered, zero at power-up
// RULE12: status survives watchdog reset, cleared by power-on
// RULE13: count write replaces value being decremented
`timescale 1ns/1ps
module prescaled_chip_watchdog
#(
	parameter int PRESC_W       = wdt_pkg::PRESC_W_DEF,
	parameter int COUNT_W       = wdt_pkg::COUNT_W_DEF,
	parameter int RST_PULSE_LEN = wdt_pkg::CHIP_RST_CYCLES
)
(
	input  wire logic           i_sys_clk,
	input  wire logic           i_rstn,
	input  wire logic           i_clk_en,
	input  wire logic           i_sys_rst_n,
	input  wire logic           i_osc_input_pin,
	input  wire logic           i_hsel,
	input  wire logic [31:0]    i_haddr,
	input  wire logic [1:0]     i_htrans,
	input  wire logic           i_hwrite,
	input  wire logic [2:0]     i_hsize,
	input  wire logic [31:0]    i_hwdata,
	input  wire logic           i_hready,
	output logic                o_hreadyout,
	output logic [31:0]         o_hrdata,
	output logic                o_hresp,
	output logic                o_chip_rst,
	output logic                o_triggered,
	output logic                o_counting
);

	// ****************************************************************
	// parameter checks
	// ****************************************************************
	generate
		if (PRESC_W < 2 || PRESC_W > wdt_pkg::PRESC_W_DEF)
		begin : g_bad_presc
			$error("prescaler width out of range");
		end
		if (COUNT_W < 2 || COUNT_W > wdt_pkg::COUNT_W_DEF)
		begin : g_bad_count
			$error("timeout count width out of range");
		end
		if (RST_PULSE_LEN < 1 || RST_PULSE_LEN > 255)
		begin : g_bad_pulse
			$error("chip reset pulse length out of range");
		end
	endgenerate

	localparam logic [PRESC_W-1:0] LIMIT_INIT = wdt_pkg::LIMIT_RST[PRESC_W-1:0];
	localparam logic [PRESC_W-1:0] PRESC_INIT = wdt_pkg::PRESC_RST[PRESC_W-1:0];
	localparam logic [COUNT_W-1:0] COUNT_INIT = wdt_pkg::COUNT_RST[COUNT_W-1:0];
	localparam logic [COUNT_W-1:0] COUNT_NIL  = wdt_pkg::COUNT_ZERO[COUNT_W-1:0];
	localparam logic [7:0]         PULSE_LAST = 8'(RST_PULSE_LEN - 1);

	// ****************************************************************
	// declarations
	// ****************************************************************
	wdt_reg_if regs ();

	logic                  osc_prev_reg;
	logic                  osc_edge;
	logic [PRESC_W-1:0]    presc_reg;
	logic [PRESC_W-1:0]    presc_next;
	logic                  presc_wrap;
	logic [PRESC_W-1:0]    limit_reg;
	logic [COUNT_W-1:0]    count_reg;
	logic [COUNT_W-1:0]    count_next;
	logic                  count_en_reg;
	logic                  trig_en_reg;
	logic                  expire;
	logic                  soft_rst;
	logic                  hist_reg;
	logic                  chip_rst_reg;
	logic [7:0]            pulse_cnt_reg;
	wdt_pkg::fire_state_t  state_reg;
	wdt_pkg::fire_state_t  state_next;
	wdt_pkg::word_t        rd_word;

	// ****************************************************************
	// bus slave
	// ****************************************************************
	wdt_ahb_slave i_wdt_ahb_slave
	(
		.i_sys_clk   (i_sys_clk),
		.i_rstn      (i_rstn),
		.i_clk_en    (i_clk_en),
		.i_hsel      (i_hsel),
		.i_haddr     (i_haddr),
		.i_htrans    (i_htrans),
		.i_hwrite    (i_hwrite),
		.i_hsize     (i_hsize),
		.i_hwdata    (i_hwdata),
		.i_hready    (i_hready),
		.o_hreadyout (o_hreadyout),
		.o_hrdata    (o_hrdata),
		.o_hresp     (o_hresp),
		.regs        (regs)
	);

	// write strobe helper, used for every writable register
	function automatic logic wr_hit(input logic [wdt_pkg::IDX_W-1:0] idx);
		return regs.wr_en && (regs.wr_idx == idx);
	endfunction : wr_hit

	// the watchdog's own reset and the system reset clear the prescaler, limit,
	// control bits and count but not the sequencer or the trigger history,
	// which only the power-on reset clears
	assign soft_rst = !i_sys_rst_n || (state_reg != wdt_pkg::ST_RUN);

	// ****************************************************************
	// oscillator edge detect
	// ****************************************************************
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			osc_prev_reg <= 1'b0;
		else if (i_clk_en)
			osc_prev_reg <= i_osc_input_pin;
	end

	assign osc_edge = i_osc_input_pin & ~osc_prev_reg;

	// ****************************************************************
	// prescaler
	// ****************************************************************
	// a limit written below the live count wraps at the next oscillator edge rather than
	// running all the way round the counter
	assign presc_wrap = osc_edge && (presc_reg >= limit_reg); // RULE7

	always_comb
	begin
		presc_next = presc_reg;
		if (presc_wrap)
			presc_next = PRESC_INIT; // RULE5
		else if (osc_edge)
			presc_next = presc_reg + 1'b1; // RULE5
	end

	// free running regardless of the control bit enables, so it serves as a timer
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			presc_reg <= PRESC_INIT;
		else if (i_clk_en)
		begin
			if (soft_rst)
				presc_reg <= PRESC_INIT;
			else
				presc_reg <= presc_next; // RULE6
		end
	end

	// ****************************************************************
	// divider limit
	// ****************************************************************
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			limit_reg <= LIMIT_INIT; // RULE7
		else if (i_clk_en)
		begin
			if (soft_rst)
				limit_reg <= LIMIT_INIT; // RULE7
			else if (wr_hit(wdt_pkg::IDX_LIMIT))
				limit_reg <= regs.wr_data[PRESC_W-1:0]; // RULE7
		end
	end

	// ****************************************************************
	// control bits
	// ****************************************************************
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			count_en_reg <= 1'b0; // RULE1
			trig_en_reg  <= 1'b0; // RULE1
		end
		else if (i_clk_en)
		begin
			if (soft_rst)
			begin
				count_en_reg <= 1'b0; // RULE1
				trig_en_reg  <= 1'b0; // RULE1
			end
			else if (wr_hit(wdt_pkg::IDX_CTRL))
			begin
				// both bits independent, so count-only is allowed
				count_en_reg <= regs.wr_data[wdt_pkg::CTRL_COUNT_EN_BIT]; // RULE4
				trig_en_reg  <= regs.wr_data[wdt_pkg::CTRL_TRIG_EN_BIT]; // RULE4
			end
		end
	end

	// ****************************************************************
	// timeout countdown
	// ****************************************************************
	// a write beats a decrement in the same cycle, so software's value
	// is never lost; the count parks at zero instead of wrapping
	always_comb
	begin
		count_next = count_reg;
		if (wr_hit(wdt_pkg::IDX_COUNT))
			count_next = regs.wr_data[COUNT_W-1:0]; // RULE13
		else if (presc_wrap && count_en_reg && (count_reg != COUNT_NIL))
			count_next = count_reg - 1'b1; // RULE2 RULE8
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			count_reg <= COUNT_INIT; // RULE8
		else if (i_clk_en)
		begin
			if (soft_rst)
				count_reg <= COUNT_INIT; // RULE8
			else
				count_reg <= count_next;
		end
	end

	// expiry needs the counter running; without the trigger bit the count
	// simply rests at zero for inspection
	assign expire = (count_reg == COUNT_NIL) && count_en_reg && trig_en_reg; // RULE3 RULE9

	// ****************************************************************
	// chip reset sequencer
	// ****************************************************************
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			wdt_pkg::ST_RUN:
			begin
				if (expire && i_sys_rst_n)
					state_next = wdt_pkg::ST_FIRE; // RULE9
			end
			wdt_pkg::ST_FIRE:
			begin
				if (pulse_cnt_reg == PULSE_LAST)
					state_next = wdt_pkg::ST_SETTLE;
			end
			wdt_pkg::ST_SETTLE:
			begin
				state_next = wdt_pkg::ST_RUN;
			end
			default:
			begin
				state_next = wdt_pkg::ST_RUN;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			state_reg <= wdt_pkg::ST_RUN;
		else if (i_clk_en)
			state_reg <= state_next;
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			pulse_cnt_reg <= '0;
		else if (i_clk_en)
		begin
			if (state_reg == wdt_pkg::ST_FIRE)
				pulse_cnt_reg <= pulse_cnt_reg + 1'b1;
			else
				pulse_cnt_reg <= '0;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			chip_rst_reg <= 1'b0;
		else if (i_clk_en)
			chip_rst_reg <= (state_next == wdt_pkg::ST_FIRE); // RULE9
	end

	// ****************************************************************
	// trigger history
	// ****************************************************************
	// only the power-on reset clears it; nothing on the bus can
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			hist_reg <= 1'b0; // RULE11 RULE12
		else if (i_clk_en && (state_next == wdt_pkg::ST_FIRE))
			hist_reg <= 1'b1; // RULE11
	end

	// ****************************************************************
	// register read mux
	// ****************************************************************
	always_comb
	begin
		rd_word = '0;
		case (regs.rd_idx)
			wdt_pkg::IDX_CTRL:
			begin
				rd_word[wdt_pkg::CTRL_COUNT_EN_BIT] = count_en_reg;
				rd_word[wdt_pkg::CTRL_TRIG_EN_BIT]  = trig_en_reg;
			end
			wdt_pkg::IDX_LIVE:
			begin
				rd_word[PRESC_W-1:0] = presc_reg; // RULE6
			end
			wdt_pkg::IDX_LIMIT:
			begin
				rd_word[PRESC_W-1:0] = limit_reg;
			end
			wdt_pkg::IDX_COUNT:
			begin
				rd_word[COUNT_W-1:0] = count_reg;
			end
			wdt_pkg::IDX_HIST:
			begin
				rd_word[wdt_pkg::HIST_TRIG_BIT] = hist_reg; // RULE11
			end
			default:
			begin
				rd_word = '0;
			end
		endcase
	end

	assign regs.rd_data = rd_word;

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign o_chip_rst  = chip_rst_reg;
	assign o_triggered = hist_reg;
	assign o_counting  = count_en_reg;

endmodule : prescaled_chip_watchdog

//--- rtl/wdt_ahb_slave.sv
// AHB-Lite slave front end for the watchdog registers
`timescale 1ns/1ps
module wdt_ahb_slave
(
	input  wire logic           i_sys_clk,
	input  wire logic           i_rstn,
	input  wire logic           i_clk_en,
	input  wire logic           i_hsel,
	input  wire logic [31:0]    i_haddr,
	input  wire logic [1:0]     i_htrans,
	input  wire logic           i_hwrite,
	input  wire logic [2:0]     i_hsize,
	input  wire logic [31:0]    i_hwdata,
	input  wire logic           i_hready,
	output logic                o_hreadyout,
	output logic [31:0]         o_hrdata,
	output logic                o_hresp,
	wdt_reg_if.bus              regs
);

	logic                          accept;
	logic                          dph_wr_reg;
	logic [wdt_pkg::IDX_W-1:0]     dph_idx_reg;
	logic [31:0]                   hrdata_reg;
	logic [wdt_pkg::IDX_W-1:0]     aph_idx;

	// non-word sizes fall to the unmapped index: read zero, write ignored
	assign accept  = i_hsel & i_htrans[1] & i_hready;
	assign aph_idx = (i_hsize == wdt_pkg::HSIZE_WORD) ? wdt_pkg::map_index(i_haddr)
	                                                  : wdt_pkg::IDX_NONE;

	// ****************************************************************
	// address phase capture
	// ****************************************************************
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			dph_wr_reg  <= 1'b0;
			dph_idx_reg <= wdt_pkg::IDX_NONE;
		end
		else if (i_clk_en && i_hready)
		begin
			dph_wr_reg  <= accept & i_hwrite;
			dph_idx_reg <= accept ? aph_idx : wdt_pkg::IDX_NONE;
		end
	end

	// read data is sampled at the address edge so hrdata comes from a flop
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			hrdata_reg <= '0;
		else if (i_clk_en && accept && !i_hwrite)
			hrdata_reg <= regs.rd_data;
	end

	assign regs.rd_idx  = aph_idx;
	assign regs.wr_en   = dph_wr_reg & i_clk_en;
	assign regs.wr_idx  = dph_idx_reg;
	assign regs.wr_data = i_hwdata;

	// a frozen block stretches the data phase instead of dropping it
	assign o_hreadyout = i_clk_en;
	assign o_hrdata    = hrdata_reg;
	assign o_hresp     = wdt_pkg::HRESP_OKAY;

endmodule : wdt_ahb_slave

//--- tb/prescaled_chip_watchdog_sva.sv
// port-level concurrent checks for the chip watchdog
`timescale 1ns/1ps
module wdt_port_checker
#(
	parameter int PRESC_W       = 16,
	parameter int COUNT_W       = 12,
	parameter int RST_PULSE_LEN = 4
)
(
	input wire logic        i_sys_clk,
	input wire logic        i_rstn,
	input wire logic        i_clk_en,
	input wire logic        o_hreadyout,
	input wire logic [31:0] o_hrdata,
	input wire logic        o_hresp,
	input wire logic        o_chip_rst,
	input wire logic        o_triggered,
	input wire logic        o_counting
);
	// ****************************************************************
	// helper: enabled cycles the chip reset request has stood
	// ****************************************************************
	logic [7:0] pulse_cnt_reg;

	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			pulse_cnt_reg <= 8'h00;
		else if (i_clk_en)
			pulse_cnt_reg <= o_chip_rst ? pulse_cnt_reg + 8'h01 : 8'h00;
	end

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rstn);

	// ****************************************************************
	// expiry steps: fire, hold, release
	// ****************************************************************
	sequence s_fire;
		$rose(o_chip_rst);
	endsequence
	sequence s_fire_ok;
		o_triggered && $past(o_counting);
	endsequence
	sequence s_end;
		$fell(o_chip_rst);
	endsequence

	chk_bus_okay: assert property (o_hresp == wdt_pkg::HRESP_OKAY)
		else $error("bus response not okay");
	chk_ready_follows: assert property (o_hreadyout == i_clk_en)
		else $error("hreadyout differs from clock enable");
	chk_rd_upper_zero: assert property (o_hrdata[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	chk_fire_effect: assert property (s_fire |-> s_fire_ok)
		else $error("chip reset without counting or history");
	chk_pulse_width: assert property (s_end |->
		pulse_cnt_reg == RST_PULSE_LEN && !o_counting)
		else $error("chip reset pulse width or config wrong");
	chk_pulse_max: assert property (pulse_cnt_reg <= RST_PULSE_LEN)
		else $error("chip reset pulse too long");
	chk_hist_sticky: assert property (o_triggered |=> o_triggered)
		else $error("trigger history cleared without power-on reset");
	chk_reset_idle: assert property ($rose(i_rstn) |->
		!o_chip_rst && !o_triggered && !o_counting)
		else $error("watchdog not idle after reset");
	chk_hist_cause: assert property ($rose(o_triggered) |-> o_chip_rst)
		else $error("history set without chip reset");
endmodule : wdt_port_checker

bind prescaled_chip_watchdog wdt_port_checker
#(
	.PRESC_W       (PRESC_W),
	.COUNT_W       (COUNT_W),
	.RST_PULSE_LEN (RST_PULSE_LEN)
)
i_wdt_port_checker
(
	.i_sys_clk, .i_rstn, .i_clk_en, .o_hreadyout, .o_hrdata, .o_hresp,
	.o_chip_rst, .o_triggered, .o_counting
);

//--- tb/tb_prescaled_chip_watchdog.sv
// self-checking bench for the chip watchdog
`timescale 1ns/1ps
module tb_prescaled_chip_watchdog;
	logic        i_sys_clk       = 1'b0;
	logic        i_rstn          = 1'b0;
	logic        i_clk_en        = 1'b1;
	logic        i_sys_rst_n     = 1'b1;
	logic        i_osc_input_pin = 1'b0;
	logic        i_hsel          = 1'b0;
	logic [31:0] i_haddr         = 32'h00000000;
	logic [1:0]  i_htrans        = 2'h0;
	logic        i_hwrite        = 1'b0;
	logic [2:0]  i_hsize         = wdt_pkg::HSIZE_WORD;
	logic [31:0] i_hwdata        = 32'h00000000;
	logic        i_hready;
	logic        o_hreadyout;
	logic [31:0] o_hrdata;
	logic        o_hresp;
	logic        o_chip_rst;
	logic        o_triggered;
	logic        o_counting;
	logic        rd_dphase       = 1'b0;
	logic [31:0] exp_q[$];
	int          num_errors      = 0;
	int          comparisons     = 0;
	int          seed            = 62;
	int          lim;

	// the only slave, so its ready is the bus ready
	assign i_hready = o_hreadyout;
	always #5 i_sys_clk = ~i_sys_clk;

	prescaled_chip_watchdog i_prescaled_chip_watchdog
	(
		.i_sys_clk, .i_rstn, .i_clk_en, .i_sys_rst_n, .i_osc_input_pin,
		.i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize, .i_hwdata, .i_hready,
		.o_hreadyout, .o_hrdata, .o_hresp, .o_chip_rst, .o_triggered, .o_counting
	);

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// a stalled enable is lifted after one edge
	task automatic wait_rdy;
		int n;
		n = 0;
		do
		begin
			@(posedge i_sys_clk);
			if (!i_clk_en)
				i_clk_en <= 1'b1;
			n++;
		end
		while (!o_hreadyout && n < 20);
		if (!o_hreadyout)
		begin
			num_errors++;
			report_and_stop();
		end
	endtask : wait_rdy

	// for a read, d is the expected word
	task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] d);
		i_hsel <= 1'b1;
		i_htrans <= 2'h2;
		i_haddr <= {14'h0000, idx, 2'h0};
		i_hwrite <= wr;
		i_clk_en <= ({$random(seed)} % 4) != 0;
		wait_rdy();
		i_hsel <= 1'b0;
		i_htrans <= 2'h0;
		i_hwdata <= d;
		rd_dphase <= !wr;
		if (!wr)
			exp_q.push_back(d);
		wait_rdy();
		rd_dphase <= 1'b0;
	endtask : bus

	task automatic osc(input int n);
		repeat (n)
		begin
			@(posedge i_sys_clk);
			i_osc_input_pin <= 1'b1;
			@(posedge i_sys_clk);
			i_osc_input_pin <= 1'b0;
		end
		repeat (3) @(posedge i_sys_clk);
	endtask : osc

	// which high watches the history output, low the chip reset request
	task automatic wait_lvl(input logic which, input logic lvl);
		int   n;
		logic seen;
		n = 0;
		seen = which ? o_triggered : o_chip_rst;
		while (seen !== lvl && n < 200)
		begin
			@(posedge i_sys_clk);
			seen = which ? o_triggered : o_chip_rst;
			n++;
		end
		check({31'h0, seen}, {31'h0, lvl});
		if (seen !== lvl)
			report_and_stop();
	endtask : wait_lvl

	task automatic pulse_rst(input logic por);
		if (por)
			i_rstn <= 1'b0;
		else
			i_sys_rst_n <= 1'b0;
		@(posedge i_sys_clk);
		i_rstn <= 1'b1;
		i_sys_rst_n <= 1'b1;
		@(posedge i_sys_clk);
	endtask : pulse_rst

	// read results are compared in the data phase's closing edge
	always @(posedge i_sys_clk)
	begin
		if (rd_dphase && o_hreadyout)
			check(o_hrdata, exp_q.pop_front());
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		repeat (6) @(posedge i_sys_clk);
		i_rstn <= 1'b1;
		@(posedge i_sys_clk);
		bus(1'b0, wdt_pkg::IDX_CTRL, 32'h00000000);
		bus(1'b0, wdt_pkg::IDX_LIVE, 32'h00000000);
		bus(1'b0, wdt_pkg::IDX_LIMIT, 32'h0000FFFF);
		bus(1'b0, wdt_pkg::IDX_COUNT, 32'h00000FFF);
		bus(1'b0, wdt_pkg::IDX_HIST, 32'h00000000);
		bus(1'b0, wdt_pkg::IDX_NONE, 32'h00000000);
		$display("test reset values done");

		lim = 2 + {$random(seed)} % 8;
		bus(1'b1, wdt_pkg::IDX_LIMIT, ($random(seed) & 32'hFFFF0000) | 32'(lim));
		bus(1'b0, wdt_pkg::IDX_LIMIT, 32'(lim));
		osc(lim + 2);
		bus(1'b0, wdt_pkg::IDX_LIVE, 32'h00000001);
		bus(1'b0, wdt_pkg::IDX_COUNT, 32'h00000FFF);
		$display("test prescaler done");

		bus(1'b1, wdt_pkg::IDX_CTRL, 32'h00000001);
		bus(1'b1, wdt_pkg::IDX_COUNT, ($random(seed) & 32'hFFFFF000) | 32'h3);
		bus(1'b0, wdt_pkg::IDX_COUNT, 32'h00000003);
		check({31'h0, o_counting}, 32'h00000001);
		osc(3 * (lim + 1));
		bus(1'b0, wdt_pkg::IDX_COUNT, 32'h00000000);
		bus(1'b1, wdt_pkg::IDX_LIVE, 32'h00000005);
		bus(1'b0, wdt_pkg::IDX_LIVE, 32'h00000001);
		check({31'h0, o_chip_rst}, 32'h00000000);
		check({31'h0, o_triggered}, 32'h00000000);
		bus(1'b1, wdt_pkg::IDX_CTRL, 32'h00000002);
		bus(1'b0, wdt_pkg::IDX_CTRL, 32'h00000002);
		repeat (4) @(posedge i_sys_clk);
		check({31'h0, o_counting}, 32'h00000000);
		check({31'h0, o_chip_rst}, 32'h00000000);
		$display("test count only done");

		bus(1'b1, wdt_pkg::IDX_COUNT, 32'h00000002);
		bus(1'b1, wdt_pkg::IDX_CTRL, 32'h00000003);
		osc(lim + 1);
		bus(1'b1, wdt_pkg::IDX_COUNT, 32'h00000002);
		osc(lim + 1);
		bus(1'b0, wdt_pkg::IDX_COUNT, 32'h00000001);
		check({31'h0, o_chip_rst}, 32'h00000000);
		osc(lim + 1);
		wait_lvl(1'b1, 1'b1);
		wait_lvl(1'b0, 1'b0);
		repeat (3) @(posedge i_sys_clk);
		bus(1'b0, wdt_pkg::IDX_HIST, 32'h00000001);
		bus(1'b0, wdt_pkg::IDX_CTRL, 32'h00000000);
		bus(1'b0, wdt_pkg::IDX_COUNT, 32'h00000FFF);
		$display("test expiry done");

		bus(1'b1, wdt_pkg::IDX_CTRL, 32'h00000001);
		pulse_rst(1'b0);
		check({31'h0, o_counting}, 32'h00000000);
		bus(1'b0, wdt_pkg::IDX_HIST, 32'h00000001);
		pulse_rst(1'b1);
		bus(1'b0, wdt_pkg::IDX_HIST, 32'h00000000);
		$display("test resets done");
		report_and_stop();
	end
endmodule : tb_prescaled_chip_watchdog
